// [core/clkgen_pkg.sv]
// Purpose: constants for the quadrature master clock generator
// Assumes: clk is the fast oscillator and counts as the 160 MHz source
// Notes: all phases come from one free-running binary counter
package clkgen_pkg;
   localparam int OSC_MHZ = 160;
   localparam int FORTY_MHZ = 40;
   localparam int FAST_DIV = OSC_MHZ / FORTY_MHZ;
   localparam int SLOW_EXTRA = 32;
   localparam int SLOW_DIV = FAST_DIV * SLOW_EXTRA;
   localparam int CNT_W = $clog2(SLOW_DIV);
   localparam int FAST_MSB = $clog2(FAST_DIV) - 1;
   localparam int SLOW_MSB = CNT_W - 1;
   localparam int NCOPY = 3;
   localparam int FE_COPY = 1;
   // count one decodes with both phases low, so no short quadrature pulse follows reset
   localparam logic [CNT_W-1:0] CNT_RST = 7'h01;
   localparam logic [1:0] SAFE_PAIR = 2'h1;
   localparam logic [NCOPY:1] OUT_RST = 3'h0;
   localparam logic SYNC_RST = 1'b0;
   typedef enum logic [1:0] {
      MODE_FAST = 2'h0,
      MODE_TO_SLOW = 2'h1,
      MODE_SLOW = 2'h3,
      MODE_TO_FAST = 2'h2
   } rate_mode_e;
endpackage

// [core/pin_sync3.sv]
// Purpose: three-stage pin synchroniser with agreement check
// Assumes: input is asynchronous to clk
// Notes: level follows once stages two and three agree
module pin_sync3
   import clkgen_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

   always_comb begin
      lvl_d = lvl_q;
      if (s2_q == s3_q) begin
         lvl_d = s3_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         lvl_q <= SYNC_RST;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule

// [core/quadrature_master_clock_gen.sv]
// Purpose: 40 MHz master clock in four phases, three copies, slowable copy one
// Assumes: clk runs at the oscillator rate; slow_req may be asynchronous
// Notes: outputs are registered, one clk behind the counter
module quadrature_master_clock_gen
   import clkgen_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow_req,
   output logic master_clk_forty,
   output logic [NCOPY:1] clk_inphase_true,
   output logic [NCOPY:1] clk_inphase_comp,
   output logic [NCOPY:1] clk_quad_true,
   output logic [NCOPY:1] clk_quad_comp,
   output logic slow_active
);
   // quadrature phase lags in-phase by a quarter of the period of bit hi
   function automatic logic quad_of(input logic hi, input logic lo);
      return ~(hi ^ lo);
   endfunction

   logic slow_lvl;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   rate_mode_e mode_q, mode_d;
   logic src_slow_q, src_slow_d;
   logic safe_now;
   logic fast_i, fast_q, slow_i, slow_q, fe_i, fe_q;
   logic forty_q, forty_d, slowact_q, slowact_d;
   logic [NCOPY:1] it_q, it_d, ic_q, ic_d, qt_q, qt_d, qc_q, qc_d;

   pin_sync3 u_slow_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin_in(slow_req),
      .level_out(slow_lvl)
   );

   // divider and phase decode
   always_comb begin
      cnt_d = cnt_q + 7'h01;
      fast_i = cnt_q[FAST_MSB];
      fast_q = quad_of(cnt_q[FAST_MSB], cnt_q[FAST_MSB-1]);
      slow_i = cnt_q[SLOW_MSB];
      slow_q = quad_of(cnt_q[SLOW_MSB], cnt_q[SLOW_MSB-1]);
      // all four of fast and slow phases low together
      safe_now = (cnt_q[FAST_MSB:FAST_MSB-1] == SAFE_PAIR) &&
                 (cnt_q[SLOW_MSB:SLOW_MSB-1] == SAFE_PAIR);
   end

   // rate switching for the front-end copy
   always_comb begin
      mode_d = mode_q;
      src_slow_d = src_slow_q;
      case (mode_q)
         MODE_FAST: begin
            if (slow_lvl) begin
               mode_d = MODE_TO_SLOW;
            end
         end
         MODE_TO_SLOW: begin
            if (!slow_lvl) begin
               mode_d = MODE_FAST;
            end else if (safe_now) begin
               mode_d = MODE_SLOW;
               src_slow_d = 1'b1;
            end
         end
         MODE_SLOW: begin
            if (!slow_lvl) begin
               mode_d = MODE_TO_FAST;
            end
         end
         MODE_TO_FAST: begin
            if (slow_lvl) begin
               mode_d = MODE_SLOW;
            end else if (safe_now) begin
               mode_d = MODE_FAST;
               src_slow_d = 1'b0;
            end
         end
         default: begin
            mode_d = MODE_FAST;
            src_slow_d = 1'b0;
         end
      endcase
   end

   // output copies
   always_comb begin
      fe_i = src_slow_q ? slow_i : fast_i;
      fe_q = src_slow_q ? slow_q : fast_q;
      it_d = {NCOPY{fast_i}};
      qt_d = {NCOPY{fast_q}};
      it_d[FE_COPY] = fe_i;
      qt_d[FE_COPY] = fe_q;
      ic_d = ~it_d;
      qc_d = ~qt_d;
      forty_d = fast_i;
      slowact_d = src_slow_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_RST;
         mode_q <= MODE_FAST;
         src_slow_q <= 1'b0;
         it_q <= OUT_RST;
         qt_q <= OUT_RST;
         ic_q <= ~OUT_RST;
         qc_q <= ~OUT_RST;
         forty_q <= 1'b0;
         slowact_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         mode_q <= mode_d;
         src_slow_q <= src_slow_d;
         it_q <= it_d;
         qt_q <= qt_d;
         ic_q <= ic_d;
         qc_q <= qc_d;
         forty_q <= forty_d;
         slowact_q <= slowact_d;
      end
   end

   assign master_clk_forty = forty_q;
   assign clk_inphase_true = it_q;
   assign clk_inphase_comp = ic_q;
   assign clk_quad_true = qt_q;
   assign clk_quad_comp = qc_q;
   assign slow_active = slowact_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_FAST_PERIOD: assert property (
      $rose(clk_inphase_true[2]) |-> ##2 $fell(clk_inphase_true[2]) ##2
         $rose(clk_inphase_true[2]))
      else $error("fast clock period is not four oscillator cycles");

   AST_QUAD_LAG: assert property (
      $rose(clk_inphase_true[3]) |-> ##1 $rose(clk_quad_true[3]))
      else $error("quadrature phase does not lag by a quarter period");

   AST_COMP_PAIR: assert property (
      (clk_inphase_comp == ~clk_inphase_true) && (clk_quad_comp == ~clk_quad_true))
      else $error("complement outputs do not mirror true outputs");

   AST_COPY_MATCH: assert property (
      (clk_inphase_true[2] == clk_inphase_true[3]) and
      (!slow_active && !$past(slow_active) |-> clk_inphase_true[1] == clk_inphase_true[2]))
      else $error("clock copies disagree");

   AST_SLOW_HIGH: assert property (
      (slow_active && $rose(clk_inphase_true[1])) |-> ##64 $fell(clk_inphase_true[1]))
      else $error("slow clock high time is not 64 oscillator cycles");

   AST_NO_RUNT: assert property (
      $rose(clk_quad_true[1]) |-> clk_quad_true[1] [*2])
      else $error("runt pulse on front-end quadrature clock");

   AST_SWITCH_SAFE: assert property (
      $changed(src_slow_q) |-> !clk_inphase_true[1] && !clk_quad_true[1])
      else $error("front-end clock source changed while a clock was high");

   AST_FORTY_COPY: assert property (
      master_clk_forty == clk_inphase_true[2])
      else $error("master clock differs from full-rate copy");

   AST_FAST_QUAD_PERIOD: assert property (
      $rose(clk_quad_true[2]) |-> ##2 $fell(clk_quad_true[2]) ##2
         $rose(clk_quad_true[2]))
      else $error("fast quadrature period is not four oscillator cycles");

   AST_FAST_QUAD_FALL: assert property (
      $fell(clk_inphase_true[2]) |-> ##1 $fell(clk_quad_true[2]))
      else $error("quadrature fall does not lag the in-phase fall");

   AST_COPIES_FULL_RATE: assert property (
      $rose(clk_inphase_true[3]) |-> ##2 $fell(clk_inphase_true[3]))
      else $error("copy three does not run at full rate");

   AST_COPY_QUAD_MATCH: assert property (
      (clk_quad_true[2] == clk_quad_true[3]) and
      (!slow_active && !$past(slow_active) |-> clk_quad_true[1] == clk_quad_true[2]))
      else $error("quadrature clock copies disagree");

   AST_SLOW_QUAD_LAG: assert property (
      (slow_active && $rose(clk_inphase_true[1])) |-> ##32 $rose(clk_quad_true[1]))
      else $error("slow quadrature does not lag by a quarter period");

   AST_SLOW_LOW: assert property (
      (slow_active && $fell(clk_inphase_true[1])) |->
         ##64 ($rose(clk_inphase_true[1]) || !slow_active))
      else $error("slow clock low time is not 64 oscillator cycles");

   AST_SLOW_QUAD_HIGH: assert property (
      (slow_active && $rose(clk_quad_true[1])) |-> ##64 $fell(clk_quad_true[1]))
      else $error("slow quadrature high time is not 64 oscillator cycles");

   AST_NO_RUNT_IHIGH: assert property (
      $rose(clk_inphase_true[1]) |-> clk_inphase_true[1] [*2])
      else $error("runt high pulse on front-end in-phase clock");

   AST_NO_RUNT_ILOW: assert property (
      $fell(clk_inphase_true[1]) |-> (!clk_inphase_true[1]) [*2])
      else $error("runt low pulse on front-end in-phase clock");

   AST_NO_RUNT_QLOW: assert property (
      $fell(clk_quad_true[1]) |-> (!clk_quad_true[1]) [*2])
      else $error("runt low pulse on front-end quadrature clock");

   AST_MODE_SOURCE: assert property (
      (mode_q == MODE_SLOW) |-> src_slow_q)
      else $error("slow mode without the slow source selected");

   AST_SWITCH_ON_REQ: assert property (
      $rose(src_slow_q) |-> $past(slow_lvl))
      else $error("front-end copy slowed without a request");

   AST_RETURN_ON_REQ: assert property (
      $fell(src_slow_q) |-> !$past(slow_lvl))
      else $error("front-end copy returned to full rate while slow was requested");

   COV_ENTER_SLOW: cover property ($rose(slow_active));
   COV_LEAVE_SLOW: cover property ($fell(slow_active));
   COV_ABORT_SWITCH: cover property (mode_q == MODE_TO_SLOW ##1 mode_q == MODE_FAST);
   COV_SLOW_QUAD_RISE: cover property (slow_active && $rose(clk_quad_true[1]));
   COV_ABORT_RETURN: cover property (mode_q == MODE_TO_FAST ##1 mode_q == MODE_SLOW);
endmodule

// [dv/fe_clock_sink.sv]
// Purpose: front-end consumer of clock copy one, tracks the shortest level run
// Assumes: fe_clk is sampled on the oscillator clock
// Notes: a glitch or shortened pulse shows as a run below two cycles
module fe_clock_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fe_clk,
   output logic [7:0] min_run
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q;
   logic [7:0] run_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 1'b0;
         run_q <= 8'h01;
         min_run <= 8'hff;
      end else if (fe_clk !== last_q) begin
         if (run_q < min_run) min_run <= run_q;
         run_q <= 8'h01;
         last_q <= fe_clk;
      end else if (run_q != 8'hff) begin
         run_q <= run_q + 8'h01;
      end
   end
endmodule

// [dv/quadrature_master_clock_gen_tb_top.sv]
// Purpose: self-checking bench for the quadrature master clock generator
// Assumes: inputs driven on the falling edge
// Notes: copy one is watched by the front-end sink model
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %0h not %0h", $time, (a), (b)); end end
module quadrature_master_clock_gen_tb_top import clkgen_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, slow_req = 1'b0, mcf, slow_active;
   logic [NCOPY:1] ipt, ipc, qt, qc;
   logic [7:0] min_run;
   int num_errors = 0, checks = 0, cycles = 0, n;
   quadrature_master_clock_gen uut (.clk(clk), .rst_n(rst_n), .slow_req(slow_req),
      .master_clk_forty(mcf), .clk_inphase_true(ipt), .clk_inphase_comp(ipc),
      .clk_quad_true(qt), .clk_quad_comp(qc), .slow_active(slow_active));
   fe_clock_sink sink (.clk(clk), .rst_n(rst_n), .fe_clk(ipt[1]), .min_run(min_run));
   always #5 clk = ~clk;
   task end_sim;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task test_fast;
      logic [7:0] ip, q;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         ip[i] = ipt[2];
         q[i] = qt[2];
         `CHK(ipc, ~ipt)
         `CHK(qc, ~qt)
         `CHK(mcf, ipt[2])
         `CHK(ipt, {3{ipt[2]}})
         `CHK(qt, {3{qt[2]}})
      end
      for (int i = 2; i < 8; i++) begin
         `CHK(ip[i], ~ip[i-2])
         `CHK(q[i], ip[i-1])
      end
      `CHK(min_run, 8'h02)
      $display("test_fast done");
   endtask
   task test_slow;
      slow_req = 1'b1;
      n = 0;
      while (slow_active !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK(slow_active, 1'b1)
      while (ipt[1] !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (qt[1] !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
         `CHK(ipt[3:2], {2{mcf}})
      end
      `CHK(n, 32)
      while (ipt[1] === 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK(n, 64)
      while (ipt[1] !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK(n, 128)
      `CHK(ipc[1], ~ipt[1])
      `CHK(min_run, 8'h02)
      $display("test_slow done");
   endtask
   task test_back;
      slow_req = 1'b0;
      n = 0;
      while (slow_active !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK(slow_active, 1'b0)
      test_fast();
      $display("test_back done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      test_fast();
      test_slow();
      test_back();
      end_sim();
   end
endmodule
